// ==== bench/ccip_link_asserts.sv ====
/*
 * Checker for the two-wire link between master end and target end.
 * Assumes the resolved bus levels and output enables of ccip_if, one clock.
 */
`timescale 1ns/1ns

module ccip_link_asserts (
    input wire logic mclk,
    input wire logic resetn,
    input wire logic scl,
    input wire logic sda,
    input wire logic scl_m_oe,
    input wire logic sda_t_oe
);
    logic scl_q, sda_q, in_frame, first_byte, rd_dir, nak_seen;
    logic [3:0] bit_idx, low_cnt;
    wire logic start_ev = scl & scl_q & sda_q & ~sda;
    wire logic stop_ev = scl & scl_q & ~sda_q & sda;
    wire logic rise_ev = scl & ~scl_q;

    // bit_idx counts scl rises in the frame, 0..8 per byte
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            scl_q <= 1'b1;
            sda_q <= 1'b1;
            in_frame <= 1'b0;
            first_byte <= 1'b1;
            rd_dir <= 1'b0;
            nak_seen <= 1'b0;
            bit_idx <= 4'h0;
            low_cnt <= 4'h0;
        end else begin
            scl_q <= scl;
            sda_q <= sda;
            low_cnt <= scl ? 4'h0 : (low_cnt == 4'hF ? low_cnt : low_cnt + 4'h1);
            if (start_ev) begin
                in_frame <= 1'b1;
                first_byte <= 1'b1;
                bit_idx <= 4'h0;
                nak_seen <= 1'b0;
            end else if (stop_ev) begin
                in_frame <= 1'b0;
                nak_seen <= 1'b0;
            end else if (rise_ev && in_frame) begin
                bit_idx <= (bit_idx == 4'h8) ? 4'h0 : bit_idx + 4'h1;
                if (bit_idx == 4'h7 && first_byte) rd_dir <= sda;
                if (bit_idx == 4'h8) first_byte <= 1'b0;
                if (bit_idx == 4'h8 && !first_byte && rd_dir && sda) nak_seen <= 1'b1;
            end
        end
    end

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!resetn);

    sequence s_start;
        start_ev;
    endsequence
    sequence s_quiet8;
        !sda_t_oe [*8];
    endsequence

    a_scl_master_only: assert property (!scl |-> scl_m_oe)
        else $error("scl low without master pull");
    a_sda_stable_high: assert property (scl && $past(scl) |-> $stable(sda_t_oe))
        else $error("target sda moved while scl high");
    a_turn_delay: assert property ($changed(sda_t_oe) |-> !scl && low_cnt inside {[4'h2:4'h6]})
        else $error("target sda change off its slot");
    a_start_quiet: assert property (s_start |-> s_quiet8)
        else $error("target drives sda after start");
    a_idle_released: assert property (!in_frame |-> !sda_t_oe)
        else $error("target drives sda outside a frame");
    a_ack_ninth_slot: assert property ($rose(sda_t_oe) && (first_byte || !rd_dir) |-> bit_idx == 4'h8)
        else $error("acknowledge outside the ninth bit");
    a_ack_held_ninth: assert property ($fell(sda_t_oe) && !rd_dir |-> bit_idx == 4'h0 && !scl)
        else $error("acknowledge released too early");
    a_nak_release: assert property (nak_seen |-> !sda_t_oe)
        else $error("target drives sda after master nack");
    c_read_nak: cover property ($rose(nak_seen));
endmodule : ccip_link_asserts

// ==== bench/clock_chip_i2c_control_port_test.sv ====
/*
 * Testbench: master end and target end joined by ccip_if, driven through the
 * master's byte commands; target registers modelled by a combinational map.
 * Assumes the rtl files and ccip_cfg.svh are compiled first.
 */
`timescale 1ns/1ns

module clock_chip_i2c_control_port_test import ccip_pkg::*;;
    logic mclk = 1'b0;
    logic resetn = 1'b0;
    logic cmd_valid = 1'b0;
    ccip_op_t cmd_op = CCIP_OP_START;
    logic [7:0] cmd_data = 8'h00;
    logic cmd_nack = 1'b0;
    logic wr_ready = 1'b1;
    logic [1:0] strap_hi = 2'h0;
    logic [1:0] strap_lo = 2'h0;
    logic cmd_ready, rsp_valid, rsp_nack, spi_selected, rd_strobe, wr_valid, wr_update;
    logic [7:0] rsp_data, wr_data;
    logic [6:0] own_address;
    logic [15:0] rd_addr, wr_addr;
    logic [24:0] wq[$];
    int bad_count = 0;
    int check_count = 0;
    int strobe_count = 0;
    wire logic [7:0] rd_data = rd_addr[7:0] ^ rd_addr[15:8] ^ 8'h5A;

    always #4 mclk = ~mclk;

    ccip_if bus ();
    // scl at 10 MHz keeps four mclk per quarter bit and a short run
    ccip_master #(.SCL_HZ(10000000)) i_ccip_master (.mclk(mclk), .resetn(resetn),
        .clk_en(1'b1), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_op(cmd_op),
        .cmd_data(cmd_data), .cmd_nack(cmd_nack), .rsp_valid(rsp_valid),
        .rsp_data(rsp_data), .rsp_nack(rsp_nack), .bus(bus));
    ccip_target i_ccip_target (.mclk(mclk), .resetn(resetn), .clk_en(1'b1),
        .port_select_strap_hi(strap_hi), .port_select_strap_lo(strap_lo),
        .spi_selected(spi_selected), .own_address(own_address), .rd_addr(rd_addr),
        .rd_strobe(rd_strobe), .rd_data(rd_data), .wr_valid(wr_valid), .wr_ready(wr_ready),
        .wr_addr(wr_addr), .wr_data(wr_data), .wr_update(wr_update), .bus(bus));
    ccip_link_asserts i_ccip_link_asserts (.mclk(mclk), .resetn(resetn), .scl(bus.scl),
        .sda(bus.sda), .scl_m_oe(bus.scl_m_oe), .sda_t_oe(bus.sda_t_oe));

    always @(posedge mclk) if (wr_valid === 1'b1 && wr_ready === 1'b1)
        wq.push_back({wr_update, wr_addr, wr_data});
    always @(posedge mclk) if (rd_strobe === 1'b1) strobe_count++;

    function automatic logic [7:0] reg_val(input logic [15:0] a);
        return a[7:0] ^ a[15:8] ^ 8'h5A;
    endfunction : reg_val

    task automatic close_out();
        if (bad_count == 0 && check_count > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : close_out

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            bad_count++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // called #1 after an edge; returns #1 after the edge where the master is idle again
    task automatic cmd(input ccip_op_t op, input logic [7:0] d, input logic n);
        int k;
        k = 0;
        while (cmd_ready !== 1'b1 && k < 2000) begin
            @(posedge mclk);
            #1;
            k++;
        end
        cmd_op = op;
        cmd_data = d;
        cmd_nack = n;
        cmd_valid = 1'b1;
        @(posedge mclk);
        #1 cmd_valid = 1'b0;
        k = 0;
        while (cmd_ready !== 1'b1 && k < 2000) begin
            @(posedge mclk);
            #1;
            k++;
        end
        if (k >= 2000) chk(32'h0, 32'h1);
    endtask : cmd

    task automatic wbyte(input logic [7:0] d, input logic nak);
        cmd(CCIP_OP_WRITE, d, 1'b0);
        chk({31'h0, rsp_valid}, 32'h1);
        chk({31'h0, rsp_nack}, {31'h0, nak});
    endtask : wbyte

    task automatic rbyte(input logic n, input logic [7:0] e);
        cmd(CCIP_OP_READ, 8'h00, n);
        chk({24'h0, rsp_data}, {24'h0, e});
    endtask : rbyte

    task automatic pop_chk(input logic [24:0] e);
        if (wq.size() == 0) chk(32'h1, 32'h0);
        else chk({7'h0, wq.pop_front()}, {7'h0, e});
    endtask : pop_chk

    task automatic settle(input logic [1:0] h, input logic [1:0] l);
        strap_hi = h;
        strap_lo = l;
        repeat (4) @(posedge mclk);
        #1;
    endtask : settle

    initial begin
        repeat (8) @(posedge mclk);
        #1 resetn = 1'b1;
        for (int h = 0; h < 3; h++) begin
            for (int l = 0; l < 3; l++) begin
                settle(2'(h), 2'(l));
                chk({31'h0, spi_selected}, (h == 2 && l == 2) ? 1 : 0);
                if (h != 2 || l != 2) chk({25'h0, own_address}, {25'h0, 4'hB, 3'(h * 3 + l)});
            end
        end
        settle(2'h1, 2'h2);
        cmd(CCIP_OP_START, 8'h00, 1'b0);
        wbyte(8'hBA, 1'b0);
        wbyte(8'h02, 1'b0);
        wbyte(8'h31, 1'b0);
        wbyte(8'h11, 1'b0);
        wbyte(8'h01, 1'b0);
        cmd(CCIP_OP_STOP, 8'h00, 1'b0);
        settle(2'h1, 2'h2);
        pop_chk({1'b0, 16'h0231, 8'h11});
        pop_chk({1'b1, 16'h0232, 8'h01});
        chk({16'h0, rd_addr}, 32'h0233);
        // a foreign address, then a second foreign one (0xBE) while the straps pick the other port
        cmd(CCIP_OP_START, 8'h00, 1'b0);
        wbyte(8'hB8, 1'b1);
        cmd(CCIP_OP_STOP, 8'h00, 1'b0);
        settle(2'h2, 2'h2);
        cmd(CCIP_OP_START, 8'h00, 1'b0);
        wbyte(8'hBE, 1'b1);
        cmd(CCIP_OP_STOP, 8'h00, 1'b0);
        settle(2'h1, 2'h2);
        cmd(CCIP_OP_START, 8'h00, 1'b0);
        wbyte(8'hBA, 1'b0);
        wbyte(8'h12, 1'b0);
        wbyte(8'h34, 1'b0);
        cmd(CCIP_OP_STOP, 8'h00, 1'b0);
        cmd(CCIP_OP_START, 8'h00, 1'b0);
        wbyte(8'hBB, 1'b0);
        rbyte(1'b0, reg_val(16'h1234));
        rbyte(1'b0, reg_val(16'h1235));
        rbyte(1'b1, reg_val(16'h1236));
        cmd(CCIP_OP_STOP, 8'h00, 1'b0);
        chk({16'h0, rd_addr}, 32'h1237);
        chk(32'(strobe_count), 32'h3);
        chk(32'(wq.size()), 32'h0);
        cmd(CCIP_OP_START, 8'h00, 1'b0);
        wbyte(8'hBA, 1'b0);
        wbyte(8'h00, 1'b0);
        wbyte(8'h40, 1'b0);
        cmd(CCIP_OP_START, 8'h00, 1'b0);
        wbyte(8'hBB, 1'b0);
        rbyte(1'b1, reg_val(16'h0040));
        cmd(CCIP_OP_STOP, 8'h00, 1'b0);
        // drain stalled: two bytes fill the buffer, the third is refused
        wr_ready = 1'b0;
        cmd(CCIP_OP_START, 8'h00, 1'b0);
        wbyte(8'hBA, 1'b0);
        wbyte(8'h00, 1'b0);
        wbyte(8'h10, 1'b0);
        wbyte(8'hAA, 1'b0);
        wbyte(8'hBB, 1'b0);
        wbyte(8'hCC, 1'b1);
        cmd(CCIP_OP_STOP, 8'h00, 1'b0);
        wr_ready = 1'b1;
        settle(2'h1, 2'h2);
        pop_chk({1'b0, 16'h0010, 8'hAA});
        pop_chk({1'b0, 16'h0011, 8'hBB});
        chk(32'(wq.size()), 32'h0);
        close_out();
    end

    initial begin
        repeat (40000) @(posedge mclk);
        bad_count++;
        close_out();
    end
endmodule : clock_chip_i2c_control_port_test

// ==== rtl/ccip_cfg.svh ====
/*
 * Constants of the two-wire control port: target address layout, strap codes,
 * the update register location and the bus clock figures.
 * Assumes it is included by its bare name wherever these values are used.
 */
`ifndef CCIP_CFG_SVH
`define CCIP_CFG_SVH

// fixed upper nibble of the 7-bit target address
`define CCIP_ADDR_UPPER 4'hB
// three-level strap codes as seen on a 2-bit strap input
`define CCIP_STRAP_LOW 2'h0
`define CCIP_STRAP_OPEN 2'h1
`define CCIP_STRAP_HIGH 2'h2
// register whose bit 0 applies all buffered writes, self-clearing
`define CCIP_UPDATE_ADDR 16'h0232
`define CCIP_UPDATE_BIT 0
// clock figures in hertz
`define CCIP_MCLK_HZ 125000000
`define CCIP_SCL_STD_HZ 100000
`define CCIP_SCL_FAST_HZ 400000
// depth of the write-side buffer
`define CCIP_WBUF_DEPTH 2

`endif

// ==== rtl/ccip_if.sv ====
/*
 * The two-wire bus between master end and target end.
 * Both lines are open drain with pull-ups; the resolved levels are worked
 * out here from the output enables, so the ends hold no tristate logic.
 */
`timescale 1ns/1ns

interface ccip_if;
    logic scl_m_o;
    logic scl_m_oe;
    logic sda_m_o;
    logic sda_m_oe;
    logic sda_t_o;
    logic sda_t_oe;
    logic scl;
    logic sda;

    // wired-and with pull-up: a line is low while any enabled driver pulls low
    assign scl = ~(scl_m_oe & ~scl_m_o);
    assign sda = ~((sda_m_oe & ~sda_m_o) | (sda_t_oe & ~sda_t_o));

    modport master (output scl_m_o, output scl_m_oe, output sda_m_o, output sda_m_oe,
                    input scl, input sda);
    modport target (output sda_t_o, output sda_t_oe, input scl, input sda);
endinterface : ccip_if

// ==== rtl/ccip_master.sv ====
/*
 * Master end of the two-wire control port: a byte engine that makes start,
 * stop, byte write and byte read with the chosen acknowledge.
 * Assumes one command at a time from same-clock logic; only sda is sampled
 * through two flip-flops. No clock stretching is expected from the target.
 */
`timescale 1ns/1ns
`include "ccip_cfg.svh"

module ccip_master import ccip_pkg::*; #(
    parameter int SCL_HZ = `CCIP_SCL_FAST_HZ
) (
    input wire logic mclk,
    input wire logic resetn,
    input wire logic clk_en,
    input wire logic cmd_valid,
    output logic cmd_ready,
    input wire ccip_op_t cmd_op,
    input wire logic [7:0] cmd_data,
    input wire logic cmd_nack,
    output logic rsp_valid,
    output logic [7:0] rsp_data,
    output logic rsp_nack,
    ccip_if.master bus
);
    // a quarter of the bus period, rounded up so the bus never runs fast
    localparam int QUARTER_RAW = (`CCIP_MCLK_HZ + 4 * SCL_HZ - 1) / (4 * SCL_HZ);
    localparam int QUARTER = (QUARTER_RAW < 1) ? 1 : QUARTER_RAW;
    localparam logic [15:0] QUARTER_LAST = 16'(QUARTER - 1);

    ccip_mstate_t state_reg;
    logic [15:0] tick_cnt_reg;
    logic [1:0] phase_reg;
    logic [3:0] bit_cnt_reg;
    logic [8:0] tx_reg;
    logic [8:0] rx_reg;
    logic scl_lo_reg;
    logic sda_lo_reg;
    logic sda_s1_reg;
    logic sda_s2_reg;
    logic rsp_valid_reg;

    wire tick = clk_en && (state_reg != CCIP_M_IDLE) && (tick_cnt_reg == QUARTER_LAST);
    wire take = clk_en && cmd_valid && (state_reg == CCIP_M_IDLE);
    wire last_phase = tick && (phase_reg == 2'h3);
    wire bit_done = last_phase && (state_reg == CCIP_M_BIT) && (bit_cnt_reg == 4'h8);
    // write sends the byte then releases for the ack; read releases then sends cmd_nack as the ack bit
    wire [8:0] tx_load = (cmd_op == CCIP_OP_WRITE) ? {cmd_data, 1'b1} : {8'hFF, cmd_nack};

    assign cmd_ready = (state_reg == CCIP_M_IDLE);
    assign rsp_valid = rsp_valid_reg;
    assign rsp_data = rx_reg[8:1];
    assign rsp_nack = rx_reg[0];
    assign bus.scl_m_o = 1'b0;
    assign bus.scl_m_oe = scl_lo_reg;
    assign bus.sda_m_o = 1'b0;
    assign bus.sda_m_oe = sda_lo_reg;

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            sda_s1_reg <= 1'b1;
            sda_s2_reg <= 1'b1;
            tick_cnt_reg <= 16'h0000;
        end else if (clk_en) begin
            sda_s1_reg <= bus.sda;
            sda_s2_reg <= sda_s1_reg;
            tick_cnt_reg <= (tick || state_reg == CCIP_M_IDLE) ? 16'h0000 : tick_cnt_reg + 16'h0001;
        end
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            state_reg <= CCIP_M_IDLE;
            phase_reg <= 2'h0;
            bit_cnt_reg <= 4'h0;
            tx_reg <= 9'h1FF;
            rx_reg <= 9'h000;
            scl_lo_reg <= 1'b0;
            sda_lo_reg <= 1'b0;
            rsp_valid_reg <= 1'b0;
        end else if (clk_en) begin
            rsp_valid_reg <= bit_done;
            if (take) begin
                phase_reg <= 2'h0;
                bit_cnt_reg <= 4'h0;
                tx_reg <= tx_load;
                unique case (cmd_op)
                    CCIP_OP_START: state_reg <= CCIP_M_START;
                    CCIP_OP_STOP: state_reg <= CCIP_M_STOP;
                    CCIP_OP_WRITE, CCIP_OP_READ: state_reg <= CCIP_M_BIT;
                endcase
            end else if (tick) begin
                phase_reg <= phase_reg + 2'h1;
                unique case (state_reg)
                    // start or repeated start: sda falls while scl is high
                    CCIP_M_START: begin
                        unique case (phase_reg)
                            2'h0: sda_lo_reg <= 1'b0;
                            2'h1: scl_lo_reg <= 1'b0;
                            2'h2: sda_lo_reg <= 1'b1;
                            2'h3: scl_lo_reg <= 1'b1;
                        endcase
                    end
                    // stop: sda rises while scl is high
                    CCIP_M_STOP: begin
                        unique case (phase_reg)
                            2'h0: sda_lo_reg <= 1'b1;
                            2'h1: scl_lo_reg <= 1'b0;
                            2'h2: sda_lo_reg <= 1'b0;
                            2'h3: scl_lo_reg <= 1'b0;
                        endcase
                    end
                    // nine pulses per byte, msb first, sda set only with scl low
                    CCIP_M_BIT: begin
                        unique case (phase_reg)
                            2'h0: sda_lo_reg <= ~tx_reg[8];
                            2'h1: scl_lo_reg <= 1'b0;
                            2'h2: rx_reg <= {rx_reg[7:0], sda_s2_reg};
                            2'h3: begin
                                scl_lo_reg <= 1'b1;
                                tx_reg <= {tx_reg[7:0], 1'b1};
                                bit_cnt_reg <= bit_cnt_reg + 4'h1;
                            end
                        endcase
                    end
                    default: ;
                endcase
                if (last_phase && (state_reg != CCIP_M_BIT || bit_cnt_reg == 4'h8)) begin
                    state_reg <= CCIP_M_IDLE;
                end
            end
        end
    end
endmodule : ccip_master

// ==== rtl/ccip_pkg.sv ====
/*
 * Types shared by both ends of the two-wire control port.
 * Assumes ccip_cfg.svh sits on the include path.
 */
package ccip_pkg;

    typedef enum logic [4:0] {
        CCIP_T_IDLE = 5'h01,
        CCIP_T_RX = 5'h02,
        CCIP_T_ACK = 5'h04,
        CCIP_T_TX = 5'h08,
        CCIP_T_MACK = 5'h10
    } ccip_tstate_t;

    typedef enum logic [3:0] {
        CCIP_M_IDLE = 4'h1,
        CCIP_M_START = 4'h2,
        CCIP_M_BIT = 4'h4,
        CCIP_M_STOP = 4'h8
    } ccip_mstate_t;

    // byte-level commands of the master end
    typedef enum logic [1:0] {
        CCIP_OP_START = 2'h0,
        CCIP_OP_STOP = 2'h1,
        CCIP_OP_WRITE = 2'h2,
        CCIP_OP_READ = 2'h3
    } ccip_op_t;

endpackage : ccip_pkg

// ==== rtl/ccip_target.sv ====
/*
 * Target end of the two-wire control port of the clock chip: address match
 * from the straps, 16-bit register pointer, reads from the control registers
 * and writes into a two-entry buffer towards the shadow registers.
 * Assumes same-clock register logic: rd_data shows the register at rd_addr
 * combinationally, and the drain side of the write buffer applies entries to
 * shadow registers, copying them live when an entry carries the update flag.
 * mclk must run far faster than scl; bus lines and straps are asynchronous.
 */
// Functional notes
// - spi only when both straps high
// - address is 1011b plus strap index
// - works at 100 kHz and 400 kHz
// - target never drives scl
// - two pointer bytes, high first, then data
// - sda changes only while scl low
// - start and stop detected while scl high
// - eight bits msb first, then acknowledge
// - acknowledge pulls sda low, nack leaves high
// - first byte is address plus direction bit
// - acknowledge only own address, else idle
// - any number of bytes per transfer
// - read bytes come from control registers
// - master nack ends read, sda released
// - master stops after final write acknowledge
// - start or stop anywhere drops partial byte
// - pointer-only write loads register pointer
// - bare read starts at current pointer
// - writes go to shadow until update
`timescale 1ns/1ns
`include "ccip_cfg.svh"

module ccip_target import ccip_pkg::*; #(
    parameter int WBUF_DEPTH = `CCIP_WBUF_DEPTH,
    parameter int WBUF_WIDTH = 25
) (
    input wire logic mclk,
    input wire logic resetn,
    input wire logic clk_en,
    input wire logic [1:0] port_select_strap_hi,
    input wire logic [1:0] port_select_strap_lo,
    output logic spi_selected,
    output logic [6:0] own_address,
    output logic [15:0] rd_addr,
    output logic rd_strobe,
    input wire logic [7:0] rd_data,
    output logic wr_valid,
    input wire logic wr_ready,
    output logic [15:0] wr_addr,
    output logic [7:0] wr_data,
    output logic wr_update,
    ccip_if.target bus
);
    localparam int WBUF_AW = (WBUF_DEPTH > 1) ? $clog2(WBUF_DEPTH) : 1;
    localparam logic [WBUF_AW:0] WBUF_FULL = (WBUF_AW + 1)'(WBUF_DEPTH);

    // strap pair to address low bits; the all-high pair belongs to spi
    function automatic logic [2:0] strap_index(input logic [1:0] hi, input logic [1:0] lo);
        logic [3:0] sum;
        sum = 4'(hi) * 4'h3 + 4'(lo);
        return sum[2:0];
    endfunction : strap_index

    function automatic logic [WBUF_AW-1:0] wbuf_next(input logic [WBUF_AW-1:0] p);
        return (p == WBUF_AW'(WBUF_DEPTH - 1)) ? '0 : p + WBUF_AW'(1);
    endfunction : wbuf_next

    ccip_tstate_t state_reg;
    logic scl_s1_reg, scl_s2_reg, scl_q_reg;
    logic sda_s1_reg, sda_s2_reg, sda_q_reg;
    logic [1:0] hi_s1_reg, hi_s2_reg, lo_s1_reg, lo_s2_reg;
    logic [3:0] bit_cnt_reg;
    logic [7:0] shift_reg;
    logic rw_reg;
    logic addr_phase_reg;
    logic [1:0] byte_idx_reg;
    logic [7:0] ptr_hi_reg;
    logic [15:0] ptr_reg;
    logic [WBUF_WIDTH-1:0] wbuf_mem [WBUF_DEPTH];
    logic [WBUF_AW-1:0] wbuf_wr_reg, wbuf_rd_reg;
    logic [WBUF_AW:0] wbuf_cnt_reg;

    // only synchronised copies feed the edge detectors
    wire scl_rise = ~scl_q_reg & scl_s2_reg;
    wire scl_fall = scl_q_reg & ~scl_s2_reg;
    wire start_seen = scl_q_reg & scl_s2_reg & sda_q_reg & ~sda_s2_reg;
    wire stop_seen = scl_q_reg & scl_s2_reg & ~sda_q_reg & sda_s2_reg;
    wire spi_mode = (hi_s2_reg == `CCIP_STRAP_HIGH) && (lo_s2_reg == `CCIP_STRAP_HIGH);
    wire [6:0] my_address = {`CCIP_ADDR_UPPER, strap_index(hi_s2_reg, lo_s2_reg)};

    wire byte_end = (state_reg == CCIP_T_RX) && scl_fall && (bit_cnt_reg == 4'h8);
    wire addr_match = (shift_reg[7:1] == my_address);
    wire wbuf_in_ready = (wbuf_cnt_reg != WBUF_FULL);
    wire is_data_byte = byte_end && !addr_phase_reg && (byte_idx_reg == 2'h2);
    // a full buffer is refused with a nack, since scl cannot be held
    wire wbuf_push = is_data_byte && wbuf_in_ready;
    wire wbuf_pop = wr_valid && wr_ready;
    wire ack_byte = addr_phase_reg ? addr_match : (byte_idx_reg != 2'h2 || wbuf_in_ready);
    wire is_update = (ptr_reg == `CCIP_UPDATE_ADDR) && shift_reg[`CCIP_UPDATE_BIT];
    wire load_after_ack = (state_reg == CCIP_T_ACK) && scl_fall && rw_reg;
    wire load_after_mack = (state_reg == CCIP_T_MACK) && scl_fall;
    wire [WBUF_WIDTH-1:0] wbuf_entry = {is_update, ptr_reg, shift_reg};
    wire [WBUF_WIDTH-1:0] wbuf_head = wbuf_mem[wbuf_rd_reg];

    assign spi_selected = spi_mode;
    assign own_address = my_address;
    assign rd_addr = ptr_reg;
    assign rd_strobe = clk_en && (load_after_ack || load_after_mack) && !start_seen && !stop_seen;
    assign wr_valid = (wbuf_cnt_reg != '0);
    assign wr_update = wbuf_head[24];
    assign wr_addr = wbuf_head[23:8];
    assign wr_data = wbuf_head[7:0];
    // open drain: pull low for acknowledge or a zero data bit
    assign bus.sda_t_o = 1'b0;
    assign bus.sda_t_oe = (state_reg == CCIP_T_ACK) || ((state_reg == CCIP_T_TX) && !shift_reg[7]);

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            {scl_s1_reg, scl_s2_reg, scl_q_reg} <= 3'h7;
            {sda_s1_reg, sda_s2_reg, sda_q_reg} <= 3'h7;
            {hi_s1_reg, hi_s2_reg, lo_s1_reg, lo_s2_reg} <= 8'h00;
        end else if (clk_en) begin
            scl_s1_reg <= bus.scl;
            scl_s2_reg <= scl_s1_reg;
            scl_q_reg <= scl_s2_reg;
            sda_s1_reg <= bus.sda;
            sda_s2_reg <= sda_s1_reg;
            sda_q_reg <= sda_s2_reg;
            hi_s1_reg <= port_select_strap_hi;
            hi_s2_reg <= hi_s1_reg;
            lo_s1_reg <= port_select_strap_lo;
            lo_s2_reg <= lo_s1_reg;
        end
    end

    // shadow-side buffer: the drain may stall, a full buffer refuses the byte
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            wbuf_wr_reg <= '0;
            wbuf_rd_reg <= '0;
            wbuf_cnt_reg <= '0;
        end else if (clk_en) begin
            if (wbuf_push) begin
                wbuf_wr_reg <= wbuf_next(wbuf_wr_reg);
            end
            if (wbuf_pop) begin
                wbuf_rd_reg <= wbuf_next(wbuf_rd_reg);
            end
            wbuf_cnt_reg <= wbuf_cnt_reg + (WBUF_AW + 1)'(wbuf_push) - (WBUF_AW + 1)'(wbuf_pop);
        end
    end

    always_ff @(posedge mclk) begin
        if (clk_en && wbuf_push) begin
            wbuf_mem[wbuf_wr_reg] <= wbuf_entry;
        end
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            state_reg <= CCIP_T_IDLE;
            bit_cnt_reg <= 4'h0;
            shift_reg <= 8'hFF;
            rw_reg <= 1'b0;
            addr_phase_reg <= 1'b0;
            byte_idx_reg <= 2'h0;
            ptr_hi_reg <= 8'h00;
            ptr_reg <= 16'h0000;
        end else if (clk_en) begin
            if (start_seen) begin
                // repeated start too; any partial byte is dropped
                state_reg <= spi_mode ? CCIP_T_IDLE : CCIP_T_RX;
                bit_cnt_reg <= 4'h0;
                shift_reg <= 8'hFF;
                addr_phase_reg <= 1'b1;
            end else if (stop_seen) begin
                state_reg <= CCIP_T_IDLE;
                shift_reg <= 8'hFF;
            end else begin
                unique case (state_reg)
                    CCIP_T_IDLE: ;
                    CCIP_T_RX: begin
                        if (scl_rise) begin
                            shift_reg <= {shift_reg[6:0], sda_s2_reg};
                            bit_cnt_reg <= bit_cnt_reg + 4'h1;
                        end
                        if (byte_end) begin
                            state_reg <= ack_byte ? CCIP_T_ACK : CCIP_T_IDLE;
                            bit_cnt_reg <= 4'h0;
                            if (addr_phase_reg) begin
                                rw_reg <= shift_reg[0];
                                byte_idx_reg <= 2'h0;
                            end else if (byte_idx_reg == 2'h0) begin
                                ptr_hi_reg <= shift_reg;
                                byte_idx_reg <= 2'h1;
                            end else if (byte_idx_reg == 2'h1) begin
                                ptr_reg <= {ptr_hi_reg, shift_reg};
                                byte_idx_reg <= 2'h2;
                            end else if (wbuf_in_ready) begin
                                ptr_reg <= ptr_reg + 16'h0001;
                            end
                        end
                    end
                    CCIP_T_ACK: begin
                        if (scl_fall) begin
                            addr_phase_reg <= 1'b0;
                            bit_cnt_reg <= 4'h0;
                            if (rw_reg) begin
                                // read starts at the current pointer
                                shift_reg <= rd_data;
                                ptr_reg <= ptr_reg + 16'h0001;
                                state_reg <= CCIP_T_TX;
                            end else begin
                                shift_reg <= 8'hFF;
                                state_reg <= CCIP_T_RX;
                            end
                        end
                    end
                    CCIP_T_TX: begin
                        if (scl_rise) begin
                            bit_cnt_reg <= bit_cnt_reg + 4'h1;
                        end
                        if (scl_fall) begin
                            // next bit only after scl falls
                            shift_reg <= {shift_reg[6:0], 1'b1};
                            if (bit_cnt_reg == 4'h8) begin
                                state_reg <= CCIP_T_MACK;
                            end
                        end
                    end
                    CCIP_T_MACK: begin
                        if (scl_rise && sda_s2_reg) begin
                            state_reg <= CCIP_T_IDLE;
                        end else if (scl_fall) begin
                            shift_reg <= rd_data;
                            ptr_reg <= ptr_reg + 16'h0001;
                            bit_cnt_reg <= 4'h0;
                            state_reg <= CCIP_T_TX;
                        end
                    end
                endcase
            end
        end
    end
endmodule : ccip_target
